// ===== src/tcc_capture_compare.sv
// capture unit and three compare units of a 16-bit timer
// assumes counter, prescaler and cpu decode sit outside; inputs are
// synchronous to clk and timer_tick is a one-cycle timer clock enable
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"

module tcc_capture_compare
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    // counter side
    input  wire tcc_word_type counter_value,
    input  wire logic         timer_tick,
    input  wire logic         counter_write,
    input  wire logic         top_reached,
    input  wire logic         bottom_reached,
    input  wire tcc_mode_type waveform_mode,
    output logic [15:0]       top_value,
    // capture control
    input  wire logic         capture_pin,
    input  wire logic         comparator_out,
    input  wire logic         comparator_capture_sel,
    input  wire logic         noise_filter_en,
    input  wire logic         edge_select,
    input  wire logic         capture_irq_enable,
    input  wire logic         capture_flag_clr,
    input  wire logic         capture_irq_ack,
    output logic              capture_flag,
    output logic              capture_irq,
    output logic [15:0]       capture_reg,
    // compare control, bit i is unit a/b/c, compare_out_mode bits 2i+1:2i
    input  wire logic [2:0]   compare_irq_enable,
    input  wire logic [2:0]   compare_flag_clr,
    input  wire logic [2:0]   compare_irq_ack,
    input  wire logic [2:0]   force_compare,
    input  wire logic [5:0]   compare_out_mode,
    output logic [2:0]        compare_flag,
    output logic [2:0]        compare_irq,
    output logic [2:0]        compare_out,
    // cpu byte port
    input  wire tcc_sel_type  cpu_sel,
    input  wire logic         cpu_hi,
    input  wire logic         cpu_wr,
    input  wire logic         cpu_rd,
    input  wire tcc_byte_type cpu_wdata,
    output logic [7:0]        cpu_rdata,
    output logic [7:0]        temp_high
);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic logic f_pwm(input tcc_mode_type m);
        return !(m == 4'h0 || m == 4'h4 || m == 4'hc);
    endfunction

    function automatic logic f_cap_top(input tcc_mode_type m);
        return m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he;
    endfunction

    // non-pwm action: 01 toggle, 10 clear, 11 set
    function automatic logic f_act(input logic [1:0] md, input logic cur);
        return (md == 2'h1) ? ~cur : (md == 2'h0) ? cur : md[0];
    endfunction

    logic         pwm;
    logic         cap_top;
    logic         upd_bottom;
    assign pwm        = f_pwm(waveform_mode);
    assign cap_top    = f_cap_top(waveform_mode);
    // phase and frequency correct modes reload at bottom
    assign upd_bottom = waveform_mode == 4'h8 || waveform_mode == 4'h9;

    // ------------------------------------------------------------
    // capture path
    // ------------------------------------------------------------
    logic [3:0]   smp_reg, smp_next;
    logic         filt_reg, filt_next;
    logic         prev_reg, prev_next;
    logic [15:0]  cap_reg, cap_next;
    logic         cflag_reg, cflag_next;
    logic         det_in;
    logic         cap_evt;
    // shared holding byte, read by the capture write path below
    logic [7:0]   temp_reg, temp_next;

    // next values of the capture path
    always_comb begin
        smp_next  = {smp_reg[2:0], comparator_capture_sel ?
                     comparator_out : capture_pin};
        filt_next = filt_reg;
        if (smp_reg == `TCC_FILT_ONE) begin
            filt_next = 1'b1;
        end else if (smp_reg == `TCC_FILT_ZER) begin
            filt_next = 1'b0;
        end
        det_in    = noise_filter_en ? filt_reg : smp_reg[0];
        prev_next = det_in;
        // edge detector is off while capture_reg defines top
        cap_evt   = !cap_top && (edge_select ? (det_in && !prev_reg)
                                 : (!det_in && prev_reg));
        cap_next  = cap_reg;
        if (cap_evt) begin
            cap_next = counter_value;
        end else if (cpu_wr && !cpu_hi && cpu_sel == `TCC_SEL_CAP
                     && cap_top) begin
            cap_next = {temp_reg, cpu_wdata};
        end
        // set wins over any clear in the same cycle
        cflag_next = (cflag_reg && !capture_flag_clr && !capture_irq_ack)
                     || cap_evt;
    end

    // registers of the capture path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            smp_reg   <= 4'h0;
            filt_reg  <= 1'b0;
            prev_reg  <= 1'b0;
            cap_reg   <= `TCC_WORD_RST;
            cflag_reg <= 1'b0;
        end else if (clk_en) begin
            smp_reg   <= smp_next;
            filt_reg  <= filt_next;
            prev_reg  <= prev_next;
            cap_reg   <= cap_next;
            cflag_reg <= cflag_next;
        end
    end

    // ------------------------------------------------------------
    // compare units and shared temp byte
    // ------------------------------------------------------------
    logic [15:0]  cmp_reg [3];
    logic [15:0]  cmp_next [3];
    logic [15:0]  buf_reg [3];
    logic [15:0]  buf_next [3];
    logic [2:0]   flag_reg, flag_next;
    logic [2:0]   out_reg, out_next;
    logic [2:0]   match;
    logic         block_reg, block_next;
    logic [7:0]   rd_reg, rd_next;
    logic         upd;
    logic         wr_lo;

    // next values of compare state, temp byte and read data
    always_comb begin
        // a counter write hides matches up to and including the next tick
        block_next = counter_write ? 1'b1
                     : (timer_tick ? 1'b0 : block_reg);
        upd   = pwm && timer_tick
                && (upd_bottom ? bottom_reached : top_reached);
        wr_lo = cpu_wr && !cpu_hi;
        temp_next = temp_reg;
        if (cpu_wr && cpu_hi) begin
            temp_next = cpu_wdata;
        end else if (cpu_rd && !cpu_hi && cpu_sel == `TCC_SEL_CAP) begin
            temp_next = cap_reg[15:8];
        end
        for (int i = 0; i < 3; i++) begin
            match[i]    = timer_tick && counter_value == cmp_reg[i]
                          && !block_reg && !counter_write;
            buf_next[i] = buf_reg[i];
            cmp_next[i] = upd ? buf_reg[i] : cmp_reg[i];
            if (wr_lo && cpu_sel == 2'(i + 1)) begin
                buf_next[i] = {temp_reg, cpu_wdata};
                if (!pwm) begin
                    cmp_next[i] = {temp_reg, cpu_wdata};
                end
            end
            flag_next[i] = (flag_reg[i] && !compare_flag_clr[i]
                            && !compare_irq_ack[i]) || match[i];
            out_next[i]  = out_reg[i];
            if (!pwm && (match[i] || force_compare[i])) begin
                out_next[i] = f_act(compare_out_mode[2*i +: 2],
                                    out_reg[i]);
            end else if (pwm && compare_out_mode[2*i+1]) begin
                // single slope form: act on match, restore at bottom
                if (match[i]) begin
                    out_next[i] = compare_out_mode[2*i];
                end else if (timer_tick && bottom_reached) begin
                    out_next[i] = ~compare_out_mode[2*i];
                end
            end
        end
        // compare bytes come straight from whichever copy cpu sees
        rd_next = rd_reg;
        if (cpu_rd) begin
            unique case (cpu_sel)
                `TCC_SEL_CAP:  rd_next = cpu_hi ? temp_reg : cap_reg[7:0];
                `TCC_SEL_CMPA: rd_next = f_byte(0);
                `TCC_SEL_CMPB: rd_next = f_byte(1);
                `TCC_SEL_CMPC: rd_next = f_byte(2);
            endcase
        end
    end

    // byte of the compare copy the cpu can reach
    function automatic logic [7:0] f_byte(input int k);
        logic [15:0] w;
        w = pwm ? buf_reg[k] : cmp_reg[k];
        return cpu_hi ? w[15:8] : w[7:0];
    endfunction

    // registers of compare state; reset clears compare_out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                cmp_reg[i] <= `TCC_WORD_RST;
                buf_reg[i] <= `TCC_WORD_RST;
            end
            flag_reg  <= 3'h0;
            out_reg   <= 3'h0;
            block_reg <= 1'b0;
            temp_reg  <= 8'h00;
            rd_reg    <= 8'h00;
        end else if (clk_en) begin
            for (int i = 0; i < 3; i++) begin
                cmp_reg[i] <= cmp_next[i];
                buf_reg[i] <= buf_next[i];
            end
            flag_reg  <= flag_next;
            out_reg   <= out_next;
            block_reg <= block_next;
            temp_reg  <= temp_next;
            rd_reg    <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign capture_reg  = cap_reg;
    assign capture_flag = cflag_reg;
    assign capture_irq  = cflag_reg && capture_irq_enable;
    assign compare_flag = flag_reg;
    assign compare_irq  = flag_reg & compare_irq_enable;
    assign compare_out  = out_reg;
    assign cpu_rdata    = rd_reg;
    assign temp_high    = temp_reg;
    assign top_value    = cap_top ? cap_reg : cmp_reg[0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_cap_copy: assert property (clk_en && cap_evt |=>
        capture_reg == $past(counter_value))
        else $error("capture value wrong");
    a_cap_flag: assert property (clk_en && cap_evt |=>
        capture_flag && capture_irq == capture_irq_enable)
        else $error("capture flag not set");
    a_flag_clear: assert property (clk_en && capture_flag_clr
        && !cap_evt |=> !capture_flag)
        else $error("capture flag not cleared");
    a_temp_load: assert property (clk_en && cpu_rd && !cpu_hi
        && cpu_sel == `TCC_SEL_CAP |=> temp_high == $past(cap_reg[15:8]))
        else $error("temp not loaded on low read");
    a_cap_wr_lock: assert property (clk_en && !cap_top && !cap_evt
        |=> capture_reg == $past(capture_reg))
        else $error("capture reg written outside top mode");
    a_filt_agree: assert property ($past(clk_en) && $rose(filt_reg)
        |-> $past(smp_reg) == `TCC_FILT_ONE)
        else $error("filter changed without agreement");
    a_cmp_flag: assert property (clk_en && match[0]
        |=> compare_flag[0])
        else $error("compare flag not set");
    a_match_block: assert property (clk_en && timer_tick
        && (block_reg || counter_write)
        |=> (compare_flag & ~$past(compare_flag)) == 3'h0)
        else $error("match not blocked");
    a_direct_wr: assert property (clk_en && wr_lo && !pwm
        && cpu_sel == `TCC_SEL_CMPA |=> cmp_reg[0] ==
        {$past(temp_reg), $past(cpu_wdata)})
        else $error("direct compare write wrong");
    a_force_noflag: assert property (clk_en && force_compare[0]
        && !match[0] && !flag_reg[0] |=> !compare_flag[0])
        else $error("force set the flag");

    c_capture: cover property (clk_en && cap_evt && noise_filter_en);
    c_buffer: cover property (clk_en && upd);
    c_force: cover property (clk_en && !pwm && force_compare[1]);

endmodule

`default_nettype wire

// ===== src/tcc_defs.svh
// constants for the timer capture / compare block
// assumes plain `define use; no code lives here
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ----------------------------------------------------------------
// register select codes on the byte port
// ----------------------------------------------------------------
`define TCC_SEL_CAP  2'h0
`define TCC_SEL_CMPA 2'h1
`define TCC_SEL_CMPB 2'h2
`define TCC_SEL_CMPC 2'h3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define TCC_WORD_RST 16'h0000
`define TCC_FILT_LEN 4
`define TCC_FILT_ONE 4'hf
`define TCC_FILT_ZER 4'h0

`endif

// ===== src/tcc_pkg.sv
// types shared by the timer capture / compare block
// assumes tcc_defs.svh supplies the numeric constants
`default_nettype none
package tcc_pkg;
    typedef logic [15:0] tcc_word_type;
    typedef logic [7:0]  tcc_byte_type;
    typedef logic [1:0]  tcc_sel_type;
    typedef logic [3:0]  tcc_mode_type;
endpackage

`default_nettype wire

// ===== tb/tcc_count_model.sv
// counter-side model: 16-bit up counter advanced on a divided tick
// assumes the bench drives run, load and load_val off the rising edge
`timescale 1ns/1ps
`default_nettype none

module tcc_count_model
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // bench control
    input  wire logic         run,
    input  wire logic         load,
    input  wire tcc_word_type load_val,
    input  wire tcc_word_type top,
    // counter side of the block
    output var tcc_word_type  counter_value,
    output logic              timer_tick,
    output logic              counter_write,
    output logic              top_reached,
    output logic              bottom_reached
);
    logic ph_reg;
    logic blk_reg;

    // tick on every second clock so gaps between ticks are exercised
    assign timer_tick     = run & ph_reg;
    assign top_reached    = counter_value == top;
    assign bottom_reached = counter_value == 16'h0000;

    // a load outranks counting and hides a top wrap on the first tick after it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_value <= 16'h0000;
            counter_write <= 1'b0;
            ph_reg        <= 1'b0;
            blk_reg       <= 1'b0;
        end else begin
            counter_write <= load;
            ph_reg        <= run & ~ph_reg;
            if (load) begin
                counter_value <= load_val;
                blk_reg       <= 1'b1;
            end else if (timer_tick) begin
                counter_value <= (top_reached && !blk_reg) ? 16'h0000
                                 : counter_value + 16'h0001;
                blk_reg       <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/timer16_capture_compare_units_tb_top.sv
// self-checking bench for the capture and compare block
// assumes src files compiled first; counter comes from the model
`timescale 1ns/1ps
`default_nettype none

module timer16_capture_compare_units_tb_top;
    import tcc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, run = 1'b0;
    logic load = 1'b0, timer_tick, counter_write, top_reached;
    logic bottom_reached, capture_flag, capture_irq;
    tcc_word_type counter_value, load_val = 16'h0000;
    tcc_mode_type waveform_mode = 4'h0;
    logic [15:0] top_value, capture_reg, top_sel, v, w;
    logic capture_pin = 1'b0, comparator_out = 1'b0;
    logic comparator_capture_sel = 1'b0, noise_filter_en = 1'b0;
    logic edge_select = 1'b1, capture_irq_enable = 1'b1;
    logic capture_flag_clr = 1'b0, capture_irq_ack = 1'b0;
    logic [2:0] compare_irq_enable = 3'h7, compare_flag_clr = 3'h0;
    logic [2:0] compare_irq_ack = 3'h0, force_compare = 3'h0;
    logic [2:0] compare_flag, compare_irq, compare_out, o;
    logic [5:0] compare_out_mode = 6'h2d; // a toggle, b set, c clear
    tcc_sel_type cpu_sel = 2'h0;
    logic cpu_hi = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
    tcc_byte_type cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata, temp_high;
    logic [15:0] regs [4];
    int errors = 0, total_checks = 0, i;

    always #10 clk = ~clk;
    // normal modes count the full range; mode 15 wraps at compare a
    assign top_sel = (waveform_mode == 4'hf) ? top_value : 16'hffff;

    tcc_capture_compare dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_write(counter_write), .top_reached(top_reached),
        .bottom_reached(bottom_reached), .waveform_mode(waveform_mode),
        .top_value(top_value), .capture_pin(capture_pin),
        .comparator_out(comparator_out),
        .comparator_capture_sel(comparator_capture_sel),
        .noise_filter_en(noise_filter_en), .edge_select(edge_select),
        .capture_irq_enable(capture_irq_enable),
        .capture_flag_clr(capture_flag_clr),
        .capture_irq_ack(capture_irq_ack), .capture_flag(capture_flag),
        .capture_irq(capture_irq), .capture_reg(capture_reg),
        .compare_irq_enable(compare_irq_enable),
        .compare_flag_clr(compare_flag_clr),
        .compare_irq_ack(compare_irq_ack), .force_compare(force_compare),
        .compare_out_mode(compare_out_mode), .compare_flag(compare_flag),
        .compare_irq(compare_irq), .compare_out(compare_out),
        .cpu_sel(cpu_sel), .cpu_hi(cpu_hi), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .temp_high(temp_high));
    tcc_count_model cnt (.clk(clk), .reset_n(reset_n), .run(run),
        .load(load), .load_val(load_val), .top(top_sel),
        .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_write(counter_write), .top_reached(top_reached),
        .bottom_reached(bottom_reached));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic nxt(input logic q, input logic [1:0] m);
        return (m == 2'h1) ? ~q : (m == 2'h0) ? q : m[0];
    endfunction
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (e !== g) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chkb(input logic e, input logic g);
        chk({15'h0000, e}, {15'h0000, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // high byte first, then the low byte that commits all 16 bits
    task automatic wr16(input tcc_sel_type s, input logic [15:0] d);
        cpu_sel = s;
        cpu_hi = 1'b1;
        cpu_wdata = d[15:8];
        cpu_wr = 1'b1;
        cyc(1);
        cpu_hi = 1'b0;
        cpu_wdata = d[7:0];
        cyc(1);
        cpu_wr = 1'b0;
        cyc(1);
    endtask
    // low byte first so a capture read freezes its high byte
    task automatic rd16(input tcc_sel_type s, output logic [15:0] d);
        cpu_sel = s;
        cpu_hi = 1'b0;
        cpu_rd = 1'b1;
        cyc(1);
        d[7:0] = cpu_rdata;
        cpu_hi = 1'b1;
        cyc(1);
        d[15:8] = cpu_rdata;
        cpu_rd = 1'b0;
        cyc(1);
    endtask
    task automatic clrcap();
        capture_flag_clr = 1'b1;
        cyc(1);
        capture_flag_clr = 1'b0;
        cyc(1);
    endtask
    task automatic ld(input logic [15:0] d);
        load_val = d;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        cyc(1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h375a3aaa));
        cyc(20);
        reset_n = 1'b1;
        cyc(1);
        chk(16'h0000, {13'h0000, compare_out});
        for (i = 0; i < 9; i++) begin
            v = 16'($urandom);
            regs[1 + i % 3] = v;
            wr16(tcc_sel_type'(1 + i % 3), v);
            chk({8'h00, v[15:8]}, {8'h00, temp_high});
        end
        for (i = 1; i < 4; i++) begin
            rd16(tcc_sel_type'(i), w);
            chk(regs[i], w);
            chk({8'h00, regs[3][15:8]}, {8'h00, temp_high});
        end
        $display("test byte port done");
        ld(16'($urandom));
        capture_pin = 1'b1;
        cyc(2);
        chkb(1'b1, capture_flag);
        chk(load_val, capture_reg);
        chkb(1'b1, capture_irq);
        capture_irq_enable = 1'b0;
        cyc(1);
        chkb(1'b0, capture_irq);
        capture_irq_enable = 1'b1;
        rd16(2'h0, w);
        chk(load_val, w);
        clrcap();
        chkb(1'b0, capture_flag);
        ld(16'($urandom));
        capture_pin = 1'b0;
        cyc(3);
        chkb(1'b0, capture_flag);
        capture_pin = 1'b1;
        cyc(2);
        chk(load_val, capture_reg);
        capture_irq_ack = 1'b1;
        cyc(1);
        capture_irq_ack = 1'b0;
        cyc(1);
        chkb(1'b0, capture_flag);
        noise_filter_en = 1'b1;
        edge_select = 1'b0;
        cyc(6);
        clrcap();
        capture_pin = 1'b0;
        cyc(3);
        capture_pin = 1'b1;
        cyc(8);
        chkb(1'b0, capture_flag);
        capture_pin = 1'b0;
        cyc(5);
        chkb(1'b0, capture_flag);
        cyc(1);
        chkb(1'b1, capture_flag);
        noise_filter_en = 1'b0;
        edge_select = 1'b1;
        comparator_capture_sel = 1'b1;
        cyc(3);
        clrcap();
        capture_pin = 1'b1;
        cyc(3);
        chkb(1'b0, capture_flag);
        comparator_out = 1'b1;
        cyc(2);
        chkb(1'b1, capture_flag);
        comparator_capture_sel = 1'b0;
        cyc(3);
        clrcap();
        w = capture_reg;
        v = 16'($urandom);
        wr16(2'h0, v);
        chk(w, capture_reg);
        waveform_mode = 4'hc;
        wr16(2'h0, v);
        chk(v, capture_reg);
        capture_pin = 1'b0;
        cyc(3);
        capture_pin = 1'b1;
        cyc(3);
        chkb(1'b0, capture_flag);
        waveform_mode = 4'h0;
        $display("test capture done");
        wr16(2'h1, 16'h0200);
        ld(16'h01fd);
        run = 1'b1;
        for (i = 0; i < 30 && compare_flag[0] !== 1'b1; i++) cyc(1);
        chk(16'h0201, counter_value);
        chkb(1'b1, compare_out[0]);
        chkb(1'b1, compare_irq[0]);
        run = 1'b0;
        compare_irq_enable = 3'h6;
        cyc(1);
        chkb(1'b0, compare_irq[0]);
        compare_irq_enable = 3'h7;
        compare_irq_ack = 3'h1;
        cyc(1);
        compare_irq_ack = 3'h0;
        cyc(1);
        chkb(1'b0, compare_flag[0]);
        ld(16'h0200);
        run = 1'b1;
        cyc(12);
        run = 1'b0;
        chkb(1'b0, compare_flag[0]);
        compare_flag_clr = 3'h7;
        cyc(1);
        compare_flag_clr = 3'h0;
        compare_out_mode[5:4] = 2'h3;
        o = compare_out;
        force_compare = 3'h6;
        cyc(1);
        force_compare = 3'h0;
        cyc(1);
        chkb(nxt(o[1], 2'h3), compare_out[1]);
        chkb(nxt(o[2], 2'h3), compare_out[2]);
        chk(16'h0000, {13'h0000, compare_flag});
        $display("test compare done");
        ld(16'h01f0);
        o = compare_out;
        waveform_mode = 4'hf;
        cyc(2);
        chk({13'h0000, o}, {13'h0000, compare_out});
        force_compare = 3'h1;
        cyc(1);
        force_compare = 3'h0;
        cyc(1);
        chkb(o[0], compare_out[0]);
        wr16(2'h1, 16'h0123);
        chk(16'h0200, top_value);
        rd16(2'h1, w);
        chk(16'h0123, w);
        run = 1'b1;
        for (i = 0; i < 200 && top_value !== 16'h0123; i++) cyc(1);
        chk(16'h0123, top_value);
        chk(16'h0000, counter_value);
        run = 1'b0;
        ld(16'h0123);
        compare_flag_clr = 3'h7;
        run = 1'b1;
        cyc(1);
        compare_flag_clr = 3'h0;
        cyc(9);
        run = 1'b0;
        chkb(1'b1, counter_value > 16'h0123);
        chkb(1'b0, compare_flag[0]);
        // dual slope mode reloads at bottom, so the wrap alone must not
        waveform_mode = 4'h9;
        wr16(2'h1, 16'h0055);
        chk(16'h0123, top_value);
        ld(16'hfffe);
        run = 1'b1;
        for (i = 0; i < 40 && top_value !== 16'h0055; i++) cyc(1);
        run = 1'b0;
        chk(16'h0055, top_value);
        chk(16'h0001, counter_value);
        $display("test buffering done");
        tally_and_finish();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        cyc(20000);
        errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
